// >>> nfc_initiator_model.sv
// Behavioural initiator that sets the field level and sends commands and framed bytes.
`timescale 1ns/1ps
`default_nettype none
module nfc_initiator_model (
  input  wire logic             clock,
  output logic [2:0]            rfLevel,
  output logic                  cmdValid,
  output nfc_target_pkg::cmd_t  cmdKind,
  output nfc_target_pkg::rate_t cmdRate,
  output logic                  rxByteValid,
  output logic [7:0]            rxByte,
  output logic                  rxIsPayload,
  output logic                  rxFrameEnd,
  output logic                  rxCheckOk
);
  initial begin
    rfLevel = 3'h0;
    cmdValid = 1'b0;
    cmdKind = nfc_target_pkg::CMD_NONE;
    cmdRate = nfc_target_pkg::RATE_106;
    rxByteValid = 1'b0;
    rxByte = 8'h00;
    rxIsPayload = 1'b0;
    rxFrameEnd = 1'b0;
    rxCheckOk = 1'b0;
  end

  task automatic field(input logic [2:0] lvl);
    @(negedge clock);
    rfLevel = lvl;
  endtask

  // The kind returns to CMD_NONE after the pulse so a design that samples late sees no command.
  task automatic command(input nfc_target_pkg::cmd_t kind, input nfc_target_pkg::rate_t rate);
    @(negedge clock);
    cmdValid = 1'b1;
    cmdKind = kind;
    cmdRate = rate;
    @(negedge clock);
    cmdValid = 1'b0;
    cmdKind = nfc_target_pkg::CMD_NONE;
  endtask

  task automatic send(input logic [7:0] data, input logic pay, input logic last, input logic ok);
    @(negedge clock);
    rxByteValid = 1'b1;
    rxByte = data;
    rxIsPayload = pay;
    rxFrameEnd = last;
    rxCheckOk = ok;
    @(negedge clock);
    rxByteValid = 1'b0;
    rxByte = ~data;
    rxFrameEnd = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> nfc_target_activation_control.sv
// Wake-up, protocol selection and data framing control of the NFC target.
// Behaviour
// - Wake field level is selectable and kept across power down.
// - Field activation powers the device up, then it awaits the first command.
// - First command sets role, rate and type, shown in the protocol register.
// - Hold pin keeps supplies on; both pins low with no field-forced enable means complete power down.
// - Nonzero detection level enables continuous antenna monitoring, even powered down.
// - Field above the level forces the internal chip enable high.
// - Stable oscillator sets its status flag and raises the field-change interrupt.
// - Protocol register top bit always shows the live field detection.
// - First initiator command raises the receive-start interrupt.
// - Host confirms enable between interrupts; internal power-up ends after the second.
// - Request commands give a passive 106 kbps target; rate may change later.
// - With automatic SDD clear, the received command goes to the FIFO.
// - Field loss at any time raises the field-change interrupt; host resets.
// - Passive 106 kbps target enables the carrier clock extractor.
// - Card emulation with request commands emulates a tag; polling gives 212/424.
// - Polling gives a passive 212/424 target; response slots timed 2.416/1.208 ms.
// - ATR first command gives an active target; collision wait ends in interrupt.
// - Type B command with tag emulation selects Type B coding and framing.
// - Received framing, CRC and parity are checked, dropped; payload reaches FIFO.
// - Active transmit encodes FIFO data with all framing added.
// - Passive transmit has no automatic collision avoidance but keeps framing.
// - Type A card emulation may run internal anticollision with a host UID.
`timescale 1ns/1ps
`default_nettype none

module nfc_target_activation_control #(
  parameter int BUF_DEPTH      = 2,
  parameter int SLOT_FIRST_CYC = nfc_target_pkg::SLOT_FIRST_CYC,
  parameter int SLOT_NEXT_CYC  = nfc_target_pkg::SLOT_NEXT_CYC,
  parameter int CA_WAIT_CYC    = nfc_target_pkg::CA_WAIT_CYC
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 levelWrite,
  input  wire logic [7:0]           levelWriteValue,
  input  wire logic                 cardEmuOption,
  input  wire logic                 tagEmuOption,
  input  wire logic                 supplyHoldPin,
  input  wire logic                 chipEnablePin,
  input  wire logic [2:0]           rfLevel,
  input  wire logic                 oscStable,
  input  wire logic                 cmdValid,
  input  wire nfc_target_pkg::cmd_t cmdKind,
  input  wire nfc_target_pkg::rate_t cmdRate,
  input  wire logic                 rateChange,
  input  wire nfc_target_pkg::rate_t rateChangeValue,
  input  wire logic                 uidLoaded,
  input  wire logic [7:0]           irqAck,
  input  wire logic                 rxByteValid,
  input  wire logic [7:0]           rxByte,
  input  wire logic                 rxIsPayload,
  input  wire logic                 rxFrameEnd,
  input  wire logic                 rxCheckOk,
  output logic                      rxReady,
  output logic [7:0]                hostData,
  output logic                      hostValid,
  input  wire logic                 hostReady,
  input  wire logic                 txValid,
  input  wire logic [7:0]           txData,
  output logic                      txReady,
  output logic [7:0]                encData,
  output logic                      encValid,
  input  wire logic                 encReady,
  output logic                      encTypeB,
  output nfc_target_pkg::rate_t     encRate,
  output logic                      encAddFraming,
  input  wire logic                 caStart,
  output logic                      carrierOn,
  output logic                      slotTick,
  output logic                      supplyOn,
  output logic                      fullPowerDown,
  output logic                      internalEnable,
  output logic                      rfMeasureEn,
  output logic                      clockExtractorEn,
  output logic                      emulateTag,
  output logic                      autoAnticollEn,
  output logic                      frameError,
  output logic [7:0]                levelOscStatus,
  output logic [7:0]                targetProtocol,
  output logic [7:0]                irqStatus,
  output logic                      irqOut
);
  localparam int PTR_W  = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CNT_W  = $clog2(BUF_DEPTH + 1);
  localparam int SLOT_W = $clog2(SLOT_FIRST_CYC + 1);
  localparam int CA_W   = $clog2(CA_WAIT_CYC + 1);
  localparam int SYNC_W = 6;
  // Pin and analog inputs all pass a two stage synchroniser.
  // The level bits settle slowly against the clock, so a torn sample lasts one cycle at most.
  logic [SYNC_W-1:0] syncA;
  logic [SYNC_W-1:0] syncB;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= {oscStable, chipEnablePin, supplyHoldPin, rfLevel};
      syncB <= syncA;
    end
  end

  wire       holdS  = syncB[3];
  wire       enS    = syncB[4];
  wire       oscS   = syncB[5];
  wire [2:0] levelS = syncB[2:0];
  // Detection level setting; power down never clears it.
  logic [2:0] detLevel;
  logic       autoSdd;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      detLevel <= '0;
      autoSdd  <= 1'b0;
    end else if (levelWrite) begin
      detLevel <= levelWriteValue[nfc_target_pkg::LEVEL_W-1:0];
      autoSdd  <= levelWriteValue[nfc_target_pkg::DET_AUTO_SDD_BIT];
    end
  end

  // Monitoring runs whenever the level is nonzero, independent of power state.
  wire measureOn   = (detLevel != 3'h0);
  wire fieldAbove  = measureOn && (levelS > detLevel);
  nfc_target_pkg::state_t state;
  nfc_target_pkg::state_t next_state;
  logic                   fieldFlag;
  logic                   isActive;
  logic                   isTypeB;
  logic                   isCardEmu;
  nfc_target_pkg::rate_t  rate;
  nfc_target_pkg::cmd_t   firstCmd;
  wire inWait     = (state == nfc_target_pkg::ST_WAIT_CMD);
  wire inTarget   = (state == nfc_target_pkg::ST_TARGET);
  wire forceEn    = (state == nfc_target_pkg::ST_WAKE) || inWait;
  wire fieldLost  = fieldFlag && !fieldAbove && (state != nfc_target_pkg::ST_OFF);
  wire oscReady   = (state == nfc_target_pkg::ST_WAKE) && oscS;
  wire firstTaken = inWait && cmdValid;
  wire isPassive  = inTarget && !isActive;
  always_comb begin
    next_state = state;
    case (state)
      nfc_target_pkg::ST_OFF: begin
        if (fieldAbove) begin
          next_state = nfc_target_pkg::ST_WAKE;
        end
      end
      nfc_target_pkg::ST_WAKE: begin
        if (oscS) begin
          next_state = nfc_target_pkg::ST_WAIT_CMD;
        end
      end
      nfc_target_pkg::ST_WAIT_CMD: begin
        if (cmdValid) begin
          next_state = nfc_target_pkg::ST_TARGET;
        end
      end
      nfc_target_pkg::ST_TARGET: begin
        next_state = nfc_target_pkg::ST_TARGET;
      end
      default: begin
        next_state = nfc_target_pkg::ST_OFF;
      end
    endcase
    if (fieldLost) begin
      next_state = nfc_target_pkg::ST_OFF;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state     <= nfc_target_pkg::ST_OFF;
      fieldFlag <= 1'b0;
    end else begin
      state     <= next_state;
      fieldFlag <= fieldAbove;
    end
  end

  // Role and coding come from the first command only; rate too, except later rate changes of a passive request target.
  wire reqCmd   = (cmdKind == nfc_target_pkg::CMD_SENS_ALL);
  wire pollCmd  = (cmdKind == nfc_target_pkg::CMD_POLLING);
  wire pollRate = (cmdRate == nfc_target_pkg::RATE_424);
  wire rateEdit = isPassive && (firstCmd == nfc_target_pkg::CMD_SENS_ALL) && rateChange;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      isActive  <= 1'b0;
      isTypeB   <= 1'b0;
      isCardEmu <= 1'b0;
      rate      <= nfc_target_pkg::RATE_106;
      firstCmd  <= nfc_target_pkg::CMD_NONE;
    end else if (firstTaken) begin
      firstCmd  <= cmdKind;
      isActive  <= (cmdKind == nfc_target_pkg::CMD_ATR);
      isTypeB   <= (cmdKind == nfc_target_pkg::CMD_TYPEB) && tagEmuOption;
      isCardEmu <= cardEmuOption && (reqCmd || pollCmd);
      if (reqCmd) begin
        rate <= nfc_target_pkg::RATE_106;
      end else if (pollCmd) begin
        rate <= pollRate ? nfc_target_pkg::RATE_424 : nfc_target_pkg::RATE_212;
      end else begin
        rate <= cmdRate;
      end
    end else if (rateEdit) begin
      rate <= rateChangeValue;
    end else if (state == nfc_target_pkg::ST_OFF) begin
      firstCmd <= nfc_target_pkg::CMD_NONE;
    end
  end

  assign targetProtocol = {fieldFlag, 1'b0, isActive, isTypeB, isCardEmu, 1'b0, rate};
  // Status and interrupt flags; a new event wins over an acknowledge in the same cycle.
  logic       oscOk;
  logic [2:0] levelReg;
  logic       caDone;
  logic [7:0] irqSet;
  always_comb begin
    irqSet = 8'h00;
    irqSet[nfc_target_pkg::IRQ_FIELD_BIT]     = oscReady || fieldLost;
    irqSet[nfc_target_pkg::IRQ_RX_START_BIT]  = firstTaken;
    irqSet[nfc_target_pkg::IRQ_COLL_DONE_BIT] = caDone;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      oscOk     <= 1'b0;
      levelReg  <= '0;
      irqStatus <= nfc_target_pkg::RESET_BYTE;
    end else begin
      oscOk     <= oscS;
      levelReg  <= levelS;
      irqStatus <= (irqStatus & ~irqAck) | irqSet;
    end
  end

  assign levelOscStatus = {1'b0, oscOk, 3'b000, levelReg};
  assign irqOut         = (irqStatus != 8'h00);
  // Power control, then clock extractor, tag emulation and anticollision enables.
  assign internalEnable = forceEn || enS;
  assign supplyOn       = holdS || internalEnable;
  assign fullPowerDown  = !holdS && !internalEnable;
  assign rfMeasureEn    = measureOn;
  assign clockExtractorEn = isPassive && (rate == nfc_target_pkg::RATE_106);
  assign emulateTag       = inTarget && isCardEmu;
  assign autoAnticollEn   = emulateTag && !isTypeB && autoSdd && uidLoaded
                            && (firstCmd == nfc_target_pkg::CMD_SENS_ALL);
  // Receive path: only payload bytes enter the buffer, framing is dropped.
  // While the first command arrives the bytes reach the host only if it runs SDD itself.
  wire rxForward = rxByteValid && rxIsPayload && (inTarget || (inWait && !autoSdd));
  logic [7:0]       mem [BUF_DEPTH];
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  logic [CNT_W-1:0] count;
  wire bufFull  = (count == CNT_W'(BUF_DEPTH));
  wire push     = rxForward && !bufFull;
  wire pop      = hostValid && hostReady;
  wire wrLast   = (wrPtr == PTR_W'(BUF_DEPTH - 1));
  wire rdLast   = (rdPtr == PTR_W'(BUF_DEPTH - 1));
  assign rxReady   = !bufFull;
  assign hostValid = (count != '0);
  assign hostData  = mem[rdPtr];
  genvar g;
  generate
    for (g = 0; g < BUF_DEPTH; g++) begin : gEntry
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          mem[g] <= nfc_target_pkg::RESET_BYTE;
        end else if (push && (wrPtr == PTR_W'(g))) begin
          mem[g] <= rxByte;
        end
      end
    end
  endgenerate
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wrPtr      <= '0;
      rdPtr      <= '0;
      count      <= '0;
      frameError <= 1'b0;
    end else begin
      if (push) begin
        wrPtr <= wrLast ? '0 : wrPtr + PTR_W'(1);
      end
      if (pop) begin
        rdPtr <= rdLast ? '0 : rdPtr + PTR_W'(1);
      end
      count      <= count + CNT_W'(push) - CNT_W'(pop);
      frameError <= rxByteValid && rxFrameEnd && !rxCheckOk;
    end
  end

  // Transmit path: one register stage towards the encoder, framing always added.
  assign txReady = inTarget && (!encValid || encReady);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      encData  <= nfc_target_pkg::RESET_BYTE;
      encValid <= 1'b0;
    end else if (!encValid || encReady) begin
      encValid <= txValid && inTarget;
      encData  <= txData;
    end
  end

  assign encTypeB      = isTypeB;
  assign encRate       = rate;
  assign encAddFraming = inTarget;
  // Collision avoidance timing exists only for the active target.
  logic [CA_W-1:0] caCnt;
  wire caGo = caStart && inTarget && isActive && !carrierOn;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      carrierOn <= 1'b0;
      caCnt     <= '0;
      caDone    <= 1'b0;
    end else begin
      caDone <= 1'b0;
      if (!inTarget) begin
        carrierOn <= 1'b0;
        caCnt     <= '0;
      end else if (caGo) begin
        carrierOn <= 1'b1;
        caCnt     <= CA_W'(CA_WAIT_CYC - 1);
      end else if (carrierOn && caCnt != '0) begin
        caCnt <= caCnt - CA_W'(1);
        caDone <= (caCnt == CA_W'(1));
      end
    end
  end

  // Slot grid for the polling response; the host picks which tick it answers on.
  logic [SLOT_W-1:0] slotCnt;
  logic              slotRun;
  wire               pollStart = firstTaken && pollCmd;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      slotRun  <= 1'b0;
      slotCnt  <= '0;
      slotTick <= 1'b0;
    end else begin
      slotTick <= 1'b0;
      if (pollStart) begin
        slotRun <= 1'b1;
        slotCnt <= SLOT_W'(SLOT_FIRST_CYC - 1);
      end else if (!inTarget) begin
        slotRun <= 1'b0;
      end else if (slotRun && slotCnt == '0) begin
        slotTick <= 1'b1;
        slotCnt  <= SLOT_W'(SLOT_NEXT_CYC - 1);
      end else if (slotRun) begin
        slotCnt <= slotCnt - SLOT_W'(1);
      end
    end
  end

  sequence wakeSeq;
    (state == nfc_target_pkg::ST_OFF) && fieldAbove ##1 (state == nfc_target_pkg::ST_WAKE);
  endsequence
  sequence firstSeq;
    inWait && cmdValid;
  endsequence
  AST_WAKE_FORCE: assert property (@(posedge clock) disable iff (!rst_n)
    wakeSeq |-> internalEnable && supplyOn)
    else $error("field detection did not force enable");
  AST_POWER_DOWN: assert property (@(posedge clock) disable iff (!rst_n)
    fullPowerDown |-> !supplyOn && !forceEn)
    else $error("power down with supply on");
  AST_OSC_IRQ: assert property (@(posedge clock) disable iff (!rst_n)
    oscReady |=> irqStatus[nfc_target_pkg::IRQ_FIELD_BIT] && levelOscStatus[nfc_target_pkg::OSC_OK_BIT])
    else $error("oscillator stable without flag and interrupt");
  AST_FIELD_BIT: assert property (@(posedge clock) disable iff (!rst_n)
    targetProtocol[nfc_target_pkg::PROT_FIELD_BIT] == $past(fieldAbove))
    else $error("field bit does not follow detection");
  AST_RX_START: assert property (@(posedge clock) disable iff (!rst_n)
    firstSeq |=> irqStatus[nfc_target_pkg::IRQ_RX_START_BIT] && !forceEn)
    else $error("first command without receive start interrupt");
  AST_PROTO_SHOW: assert property (@(posedge clock) disable iff (!rst_n)
    firstSeq ##0 (cmdKind == nfc_target_pkg::CMD_ATR)
      |=> targetProtocol[nfc_target_pkg::PROT_ACTIVE_BIT] && (encRate == $past(cmdRate)))
    else $error("active role not shown after ATR");
  AST_REQ_106: assert property (@(posedge clock) disable iff (!rst_n)
    firstSeq ##0 reqCmd |=> clockExtractorEn && (rate == nfc_target_pkg::RATE_106))
    else $error("request command did not give passive 106 target");
  AST_FIELD_LOSS: assert property (@(posedge clock) disable iff (!rst_n)
    fieldLost |=> irqStatus[nfc_target_pkg::IRQ_FIELD_BIT] && (state == nfc_target_pkg::ST_OFF))
    else $error("field loss not reported");
  AST_CA_DONE: assert property (@(posedge clock) disable iff (!rst_n)
    caGo |=> carrierOn throughout (##[1:300] irqStatus[nfc_target_pkg::IRQ_COLL_DONE_BIT]))
    else $error("collision avoidance did not finish");
  AST_PASSIVE_NO_CA: assert property (@(posedge clock) disable iff (!rst_n)
    isPassive |-> !carrierOn)
    else $error("carrier on in passive target");
  AST_AUTO_SDD: assert property (@(posedge clock) disable iff (!rst_n)
    inWait && !autoSdd && rxByteValid && rxIsPayload && rxReady |=> hostValid)
    else $error("first command byte not placed in buffer");
endmodule

`default_nettype wire

// >>> nfc_target_activation_control_bench.sv
// Self-checking bench of the NFC target activation control.
`timescale 1ns/1ps
`default_nettype none
module nfc_target_activation_control_bench;
  logic clock, rst_n, levelWrite, cardEmuOption, tagEmuOption, supplyHoldPin, chipEnablePin;
  logic oscStable, rateChange, uidLoaded, hostReady, txValid, encReady, caStart;
  logic cmdValid, rxByteValid, rxIsPayload, rxFrameEnd, rxCheckOk, rxReady, hostValid;
  logic txReady, encValid, encTypeB, encAddFraming, carrierOn, slotTick, supplyOn;
  logic fullPowerDown, internalEnable, rfMeasureEn, clockExtractorEn, emulateTag;
  logic autoAnticollEn, frameError, irqOut;
  logic [2:0] rfLevel;
  logic [7:0] levelWriteValue, irqAck, txData, rxByte, hostData, encData, expProt;
  logic [7:0] levelOscStatus, targetProtocol, irqStatus;
  nfc_target_pkg::rate_t rateChangeValue, cmdRate, encRate;
  nfc_target_pkg::cmd_t cmdKind;
  int errCount, nTests, k;
  nfc_target_pkg::cmd_t kinds [5] = '{nfc_target_pkg::CMD_SENS_ALL, nfc_target_pkg::CMD_POLLING,
    nfc_target_pkg::CMD_ATR, nfc_target_pkg::CMD_TYPEB, nfc_target_pkg::CMD_SENS_ALL};
  nfc_target_pkg::rate_t rates [5] = '{nfc_target_pkg::RATE_106, nfc_target_pkg::RATE_424,
    nfc_target_pkg::RATE_212, nfc_target_pkg::RATE_106, nfc_target_pkg::RATE_106};

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Short slot and wait counts keep the run brief; expectations below follow them.
  nfc_target_activation_control #(.BUF_DEPTH(2), .SLOT_FIRST_CYC(40), .SLOT_NEXT_CYC(20),
    .CA_WAIT_CYC(10)) uut (.clock, .rst_n, .levelWrite, .levelWriteValue, .cardEmuOption,
    .tagEmuOption, .supplyHoldPin, .chipEnablePin, .rfLevel, .oscStable, .cmdValid, .cmdKind,
    .cmdRate, .rateChange, .rateChangeValue, .uidLoaded, .irqAck, .rxByteValid, .rxByte,
    .rxIsPayload, .rxFrameEnd, .rxCheckOk, .rxReady, .hostData, .hostValid, .hostReady,
    .txValid, .txData, .txReady, .encData, .encValid, .encReady, .encTypeB, .encRate,
    .encAddFraming, .caStart, .carrierOn, .slotTick, .supplyOn, .fullPowerDown,
    .internalEnable, .rfMeasureEn, .clockExtractorEn, .emulateTag, .autoAnticollEn,
    .frameError, .levelOscStatus, .targetProtocol, .irqStatus, .irqOut);

  nfc_initiator_model peer (.clock, .rfLevel, .cmdValid, .cmdKind, .cmdRate, .rxByteValid,
    .rxByte, .rxIsPayload, .rxFrameEnd, .rxCheckOk);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    nTests++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic ack(input logic [7:0] mask);
    @(negedge clock);
    irqAck = mask;
    @(negedge clock);
    irqAck = 8'h00;
  endtask

  task automatic pulse_ca();
    @(negedge clock);
    caStart = 1'b1;
    @(negedge clock);
    caStart = 1'b0;
  endtask

  // Bounded so that a flag that never shows cannot hang the run.
  task automatic count_edges(input logic useSlot, output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (n < 300 && (useSlot ? slotTick : irqStatus[1]) !== 1'b1);
  endtask

  task automatic pop(input logic [7:0] exp);
    check(hostValid, 1'b1, "host valid");
    check(hostData, exp, "host data");
    @(negedge clock);
    hostReady = 1'b1;
    @(negedge clock);
    hostReady = 1'b0;
  endtask

  task automatic wake();
    peer.field(3'h5);
    cycles(5);
    check(internalEnable, 1'b1, "self enable");
    check(targetProtocol[7], 1'b1, "field bit");
    @(negedge clock);
    oscStable = 1'b1;
    cycles(5);
    check(irqStatus[2], 1'b1, "field irq");
    check(levelOscStatus[6], 1'b1, "osc ok");
    ack(8'h04);
    check(internalEnable, 1'b1, "waits powered");
    chipEnablePin = 1'b1;
  endtask

  task automatic lose();
    peer.field(3'h0);
    cycles(5);
    check(irqStatus[2], 1'b1, "loss irq");
    check(targetProtocol[7], 1'b0, "field bit low");
    ack(8'hff);
    oscStable = 1'b0;
    chipEnablePin = 1'b0;
  endtask

  task automatic passive_checks();
    check(clockExtractorEn, 1'b1, "extractor");
    pulse_ca();
    cycles(2);
    check(carrierOn, 1'b0, "no avoidance");
    @(negedge clock);
    rateChange = 1'b1;
    rateChangeValue = nfc_target_pkg::RATE_424;
    @(negedge clock);
    rateChange = 1'b0;
    cycles(1);
    check(targetProtocol[1:0], nfc_target_pkg::RATE_424, "rate change");
    peer.send(8'h50, 1'b0, 1'b0, 1'b1);
    peer.send(8'ha1, 1'b1, 1'b0, 1'b1);
    peer.send(8'ha2, 1'b1, 1'b0, 1'b1);
    check(rxReady, 1'b0, "buffer full");
    peer.send(8'ha3, 1'b1, 1'b0, 1'b1);
    pop(8'ha1);
    pop(8'ha2);
    check(hostValid, 1'b0, "drained");
    peer.send(8'hee, 1'b0, 1'b1, 1'b0);
    check(frameError, 1'b1, "bad check");
    check(txReady, 1'b1, "tx ready");
    @(negedge clock);
    txValid = 1'b1;
    txData = 8'h5a;
    @(negedge clock);
    txValid = 1'b0;
    cycles(2);
    check({encValid, encAddFraming}, 2'b11, "tx framed");
    check(encData, 8'h5a, "tx data");
    @(negedge clock);
    encReady = 1'b1;
    @(negedge clock);
    encReady = 1'b0;
    check(encValid, 1'b0, "tx done");
  endtask

  task automatic stop_test();
    if (errCount == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #60000;
    errCount++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    {levelWrite, cardEmuOption, tagEmuOption, supplyHoldPin, chipEnablePin, oscStable} = '0;
    {rateChange, uidLoaded, hostReady, txValid, encReady, caStart} = '0;
    {levelWriteValue, irqAck, txData} = '0;
    rateChangeValue = nfc_target_pkg::RATE_106;
    repeat (8) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    cycles(3);
    check({supplyOn, fullPowerDown}, 2'b01, "power down");
    @(negedge clock);
    supplyHoldPin = 1'b1;
    levelWrite = 1'b1;
    levelWriteValue = 8'h03;
    @(negedge clock);
    levelWrite = 1'b0;
    peer.field(3'h3);
    cycles(5);
    check({supplyOn, fullPowerDown}, 2'b10, "hold on");
    check(rfMeasureEn, 1'b1, "measure on");
    check(internalEnable, 1'b0, "level not exceeded");
    for (int i = 0; i < 5; i++) begin
      @(negedge clock);
      cardEmuOption = (i == 4);
      tagEmuOption = (i == 3);
      uidLoaded = (i == 4);
      levelWrite = (i == 4);
      levelWriteValue = 8'h23;
      @(negedge clock);
      levelWrite = 1'b0;
      wake();
      if (i == 0 || i == 4) begin
        peer.send(8'h26, 1'b1, 1'b1, 1'b1);
        check(hostValid, (i == 0), "first command byte");
      end
      if (i == 0) begin
        pop(8'h26);
      end
      peer.command(kinds[i], rates[i]);
      if (i == 1) begin
        count_edges(1'b1, k);
        check(8'(k), 8'h28, "first slot");
        count_edges(1'b1, k);
        check(8'(k), 8'h14, "next slot");
      end
      cycles(1);
      expProt = 8'h80 | 8'(rates[i]) | (8'(i == 2) << nfc_target_pkg::PROT_ACTIVE_BIT)
        | (8'(i == 3) << nfc_target_pkg::PROT_TYPEB_BIT)
        | (8'(i == 4) << nfc_target_pkg::PROT_CARDEMU_BIT);
      check(targetProtocol, expProt, "protocol");
      check({irqStatus[6], irqOut}, 2'b11, "rx start");
      check(internalEnable, 1'b1, "host enable");
      ack(8'h40);
      case (i)
        0: passive_checks();
        2: begin
          pulse_ca();
          count_edges(1'b0, k);
          check(8'(k), 8'h0a, "avoid wait");
          check(carrierOn, 1'b1, "carrier");
          check(encRate, nfc_target_pkg::RATE_212, "active rate");
        end
        3: check(encTypeB, 1'b1, "type b");
        4: begin
          check({emulateTag, clockExtractorEn}, 2'b11, "tag emulation");
          check(autoAnticollEn, 1'b1, "internal anticollision");
        end
        default: ;
      endcase
      lose();
    end
    @(negedge clock);
    supplyHoldPin = 1'b0;
    cycles(3);
    check({supplyOn, fullPowerDown}, 2'b01, "complete power down");
    check(rfMeasureEn, 1'b1, "level kept");
    stop_test();
  end
endmodule
`default_nettype wire

// >>> nfc_target_pkg.sv
// Package with constants and types of the NFC target activation control.
package nfc_target_pkg;

  localparam int CLOCK_MHZ = 200;

  // Response slot timing of a polled passive target, in microseconds scaled by 1000.
  localparam int SLOT_FIRST_NS = 2416000;
  localparam int SLOT_NEXT_NS  = 1208000;
  localparam int SLOT_FIRST_CYC = SLOT_FIRST_NS / 1000 * CLOCK_MHZ;
  localparam int SLOT_NEXT_CYC  = SLOT_NEXT_NS / 1000 * CLOCK_MHZ;

  // Minimum collision avoidance wait of an active target.
  localparam int CA_WAIT_NS  = 1000;
  localparam int CA_WAIT_CYC = (CA_WAIT_NS * CLOCK_MHZ + 999) / 1000;

  localparam int LEVEL_W = 3;

  // Detection level register layout.
  localparam int DET_AUTO_SDD_BIT = 5;

  // Interrupt status register layout.
  localparam int IRQ_COLL_DONE_BIT = 1;
  localparam int IRQ_FIELD_BIT     = 2;
  localparam int IRQ_RX_START_BIT  = 6;

  // Level and oscillator status register layout.
  localparam int OSC_OK_BIT = 6;

  // Target protocol register layout.
  localparam int PROT_FIELD_BIT   = 7;
  localparam int PROT_ACTIVE_BIT  = 5;
  localparam int PROT_TYPEB_BIT   = 4;
  localparam int PROT_CARDEMU_BIT = 3;
  localparam int PROT_RATE_LSB    = 0;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_SENS_ALL,
    CMD_POLLING,
    CMD_ATR,
    CMD_TYPEB
  } cmd_t;

  typedef enum logic [1:0] {
    RATE_106,
    RATE_212,
    RATE_424
  } rate_t;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_WAKE,
    ST_WAIT_CMD,
    ST_TARGET
  } state_t;

endpackage

// >>> nfc_target_pkg_unused_guard.sv
// Holds no code of its own; shared definitions live in the package file.
